/* common/pcis_pkg.sv */
// Purpose: shared constants for the socket interface status register
// Assumes: 12-bit socket register offsets, 8-bit register data
// Notes:   bit positions and encodings of the status byte live here
package pcis_pkg;
   // register decode
   localparam logic [11:0] STATUS_OFFSET  = 12'h801;
   localparam logic [7:0]  STATUS_LOCAL   = 8'h01;
   // status byte field positions
   localparam int          BIT_RSVD       = 7;
   localparam int          BIT_POWER      = 6;
   localparam int          BIT_READY      = 5;
   localparam int          BIT_WP         = 4;
   localparam int          BIT_SEAT2      = 3;
   localparam int          BIT_SEAT1      = 2;
   localparam int          BIT_BATT_HI    = 1;
   localparam int          BIT_BATT_LO    = 0;
   // synchronised pin vector index
   localparam int          PIN_READY      = 0;
   localparam int          PIN_WP         = 1;
   localparam int          PIN_CD1_N      = 2;
   localparam int          PIN_CD2_N      = 3;
   localparam int          PIN_BVD1       = 4;
   localparam int          PIN_BVD2       = 5;
   localparam int          PIN_COUNT      = 6;
   // battery level encodings (memory cards)
   localparam logic [1:0]  BATT_LOW       = 2'h2;
   localparam logic [1:0]  BATT_GOOD      = 2'h3;
   // reset values
   localparam logic [7:0]  DATA_RESET     = 8'h00;
   localparam logic [5:0]  PINS_RESET     = 6'h00;
endpackage

/* logic/pcis_status.sv */
// Purpose: read-only socket interface status byte with pin synchronisers
// Assumes: one clock, pins asynchronous, power state from same clock
// Notes:   write strobes to the status offset are accepted and dropped
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] bit 7 always reads zero; writes to it have no effect
// [R2] bit 6 reads 1 when socket vcc and vpp are on
// [R3] bit 5 mirrors the card ready pin
// [R4] bit 4 mirrors the write protect pin, 1 means read-only
// [R5] bit 3 reads 1 when second card-detect pin is low
// [R6] bit 2 reads 1 when first card-detect pin is low
// [R7] memory card: bit 0 carries bvd1, bit 1 carries bvd2
// [R8] battery field: 00/01 dead, 10 low warning, 11 good
// [R9] io card: bit 1 carries speaker, bit 0 carries status change
// [R10] whole register read-only, decoded at offset 801h
// [R11] after reset upper bits zero, lower bits follow socket pins
// [R12] memory window write protect from window high-byte bit, separate
// [R13] socket pins pass two flip-flops before use
module pcis_status (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   // host register access
   input  wire logic [11:0] i_addr,
   input  wire logic        i_rd_en,
   input  wire logic        i_wr_en,
   input  wire logic [7:0]  i_wr_data,
   output logic      [7:0]  o_rd_data,
   output logic             o_rd_hit,
   // socket state from the power and control logic
   input  wire logic        i_vcc_on,
   input  wire logic        i_vpp_on,
   input  wire logic        i_io_card,
   // memory window protection
   input  wire logic        i_win_wp_en,
   input  wire logic        i_win_wr_req,
   output logic             o_win_wr_allow,
   // card pins (asynchronous)
   input  wire logic        i_card_ready,
   input  wire logic        i_card_wp,
   input  wire logic        i_cd1_n,
   input  wire logic        i_cd2_n,
   input  wire logic        i_bvd1_stschg,
   input  wire logic        i_bvd2_spkr,
   // decoded battery level, memory cards only
   output logic             o_batt_dead,
   output logic             o_batt_low,
   output logic             o_batt_good
);

   typedef struct packed {
      logic [pcis_pkg::PIN_COUNT-1:0] meta;
      logic [pcis_pkg::PIN_COUNT-1:0] pins;
      logic [7:0]                     rd_data;
      logic                           rd_hit;
   } pcis_state_t;

   pcis_state_t state_r;
   pcis_state_t state_nxt;
   logic [7:0]  status_w;
   logic [pcis_pkg::PIN_COUNT-1:0] raw_w;
   logic        sel_w;
   logic [1:0]  batt_w;

   // raw pin vector, only the first sync stage reads it
   assign raw_w = {i_bvd2_spkr, i_bvd1_stschg, i_cd2_n, i_cd1_n,
                   i_card_wp, i_card_ready};
   assign sel_w = (i_addr == pcis_pkg::STATUS_OFFSET); // [R10]

   // status byte assembled from synchronised pins and the unsynchronised power inputs
   always_comb begin
      status_w = pcis_pkg::DATA_RESET;
      status_w[pcis_pkg::BIT_RSVD]  = 1'b0;                    // [R1]
      status_w[pcis_pkg::BIT_POWER] = i_vcc_on & i_vpp_on;     // [R2]
      status_w[pcis_pkg::BIT_READY] =
         state_r.pins[pcis_pkg::PIN_READY];                    // [R3]
      status_w[pcis_pkg::BIT_WP]    =
         state_r.pins[pcis_pkg::PIN_WP];                       // [R4]
      status_w[pcis_pkg::BIT_SEAT2] =
         ~state_r.pins[pcis_pkg::PIN_CD2_N];                   // [R5]
      status_w[pcis_pkg::BIT_SEAT1] =
         ~state_r.pins[pcis_pkg::PIN_CD1_N];                   // [R6]
      // same pins carry bvd or spkr/stschg; the card type decides meaning
      status_w[pcis_pkg::BIT_BATT_LO] =
         state_r.pins[pcis_pkg::PIN_BVD1];                     // [R7] [R9]
      status_w[pcis_pkg::BIT_BATT_HI] =
         state_r.pins[pcis_pkg::PIN_BVD2];                     // [R7] [R9]
   end

   // battery decode is meaningless for io cards, so it is forced quiet
   assign batt_w = status_w[pcis_pkg::BIT_BATT_HI:pcis_pkg::BIT_BATT_LO];
   assign o_batt_good = ~i_io_card & (batt_w == pcis_pkg::BATT_GOOD);// [R8]
   assign o_batt_low  = ~i_io_card & (batt_w == pcis_pkg::BATT_LOW); // [R8]
   assign o_batt_dead = ~i_io_card & ~batt_w[pcis_pkg::BIT_BATT_HI]; // [R8]

   // window protection is independent of the card's own wp pin
   assign o_win_wr_allow = i_win_wr_req & ~i_win_wp_en;              // [R12]

   // next state: sync chain and registered read answer
   always_comb begin
      state_nxt      = state_r;
      state_nxt.meta = raw_w;                                        // [R13]
      state_nxt.pins = state_r.meta;                                 // [R13]
      state_nxt.rd_hit  = i_rd_en & sel_w;
      // unmapped or idle cycles answer zero; writes never land
      state_nxt.rd_data = (i_rd_en & sel_w) ? status_w
                                            : pcis_pkg::DATA_RESET; // [R10]
   end

   // pins clear at reset and follow the socket two edges later
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r.meta    <= pcis_pkg::PINS_RESET;                    // [R11]
         state_r.pins    <= pcis_pkg::PINS_RESET;
         state_r.rd_data <= pcis_pkg::DATA_RESET;
         state_r.rd_hit  <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // registered answer; zero between reads keeps the bus quiet
   assign o_rd_data = state_r.rd_data;
   assign o_rd_hit  = state_r.rd_hit;

   // checks: reserved and power bits of the answer
   a_top_bit_zero: assert property ( // [R1]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      o_rd_data[pcis_pkg::BIT_RSVD] == 1'b0)
      else $error("reserved status bit read as one");

   a_power_flag: assert property ( // [R2]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd_en && sel_w) |=> o_rd_data[pcis_pkg::BIT_POWER] ==
         ($past(i_vcc_on) && $past(i_vpp_on)))
      else $error("power flag does not follow socket supply");

   // synchronised pins, two edges behind the socket
   a_ready_sync: assert property ( // [R3]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      1'b1 ##2
         (status_w[pcis_pkg::BIT_READY] == $past(i_card_ready, 2)))
      else $error("ready flag not two cycles behind pin");

   a_wp_sync: assert property ( // [R4]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(i_card_wp) ##2 1'b1 |-> status_w[pcis_pkg::BIT_WP])
      else $error("write protect flag missed pin rise");

   a_seat2_inv: assert property ( // [R5]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!i_cd2_n) [*3] |-> status_w[pcis_pkg::BIT_SEAT2])
      else $error("second seat flag not set for low pin");

   a_seat1_inv: assert property ( // [R6]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_cd1_n [*3] |-> !status_w[pcis_pkg::BIT_SEAT1])
      else $error("first seat flag set for high pin");

   a_seat1_fall: assert property ( // [R6]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(i_cd1_n) ##2 1'b1 |-> status_w[pcis_pkg::BIT_SEAT1])
      else $error("first seat flag missed pin fall");

   a_batt_bits: assert property ( // [R7] [R9]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      1'b1 ##2
         (batt_w == {$past(i_bvd2_spkr, 2), $past(i_bvd1_stschg, 2)}))
      else $error("battery field does not follow pins");

   // battery decode, held quiet while an io card is seated
   a_batt_decode: assert property ( // [R8]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_io_card |-> $onehot({o_batt_dead, o_batt_low, o_batt_good}))
      else $error("battery level decode not exclusive");

   a_batt_good_pins: assert property ( // [R8]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      1'b1 ##2 ($past(i_bvd2_spkr, 2) && $past(i_bvd1_stschg, 2) &&
         !i_io_card) |-> o_batt_good)
      else $error("good battery pins not decoded as good");

   a_batt_dead_pin: assert property ( // [R8]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      1'b1 ##2 (!$past(i_bvd2_spkr, 2) && !i_io_card) |-> o_batt_dead)
      else $error("dead battery pins not decoded as dead");

   a_batt_quiet: assert property ( // [R9]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_io_card |-> !(o_batt_dead || o_batt_low || o_batt_good))
      else $error("battery decode active for io card");

   // register decode; writes must leave no trace
   a_read_decode: assert property ( // [R10]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !(i_rd_en && sel_w) |=>
         (o_rd_data == pcis_pkg::DATA_RESET && !o_rd_hit))
      else $error("answer outside status offset read");

   a_hit_pulse: assert property ( // [R10]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd_en && sel_w) |=> o_rd_hit)
      else $error("status read not acknowledged");

   a_write_ignored: assert property ( // [R10]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr_en && sel_w && !i_rd_en) ##1 (i_rd_en && sel_w) |=>
         o_rd_data == $past(status_w))
      else $error("write disturbed status read");

   // window gate and reset state
   a_window_wp: assert property ( // [R12]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_win_wp_en |-> !o_win_wr_allow)
      else $error("write passed protected window");

   a_window_open: assert property ( // [R12]
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_win_wr_req && !i_win_wp_en) |-> o_win_wr_allow)
      else $error("unprotected window write blocked");

   a_reset_upper: assert property ( // [R11]
      @(posedge i_ref_clk)
      $rose(i_rstn) |->
         o_rd_data[pcis_pkg::BIT_RSVD:pcis_pkg::BIT_POWER] == 2'h0)
      else $error("upper bits not zero after reset");

endmodule

`default_nettype wire

/* tb/pcis_card_model.sv */
// Purpose: card in the socket, drives its status pins
// Assumes: pin levels chosen by the bench off the clock edge
// Notes:   detect pins active low, as a real card grounds them
`timescale 1ns/1ps
`default_nettype none
module pcis_card_model (
   // wanted pin levels
   input  wire logic [5:0] i_state,
   // socket pins
   output logic            o_card_ready,
   output logic            o_card_wp,
   output logic            o_cd1_n,
   output logic            o_cd2_n,
   output logic            o_bvd1_stschg,
   output logic            o_bvd2_spkr
);
   // pins always driven; a card never floats them while seated
   assign {o_bvd2_spkr, o_bvd1_stschg, o_cd2_n, o_cd1_n, o_card_wp,
           o_card_ready} = i_state;
endmodule
`default_nettype wire

/* tb/pcis_status_bench.sv */
// Purpose: self-checking bench for the socket interface status byte
// Assumes: reads pulse one cycle, answer one cycle later
// Notes:   driver queues expected bytes, negedge monitor compares
`timescale 1ns/1ps
`default_nettype none
module pcis_status_bench;
   logic        i_ref_clk, i_rstn, i_rd_en, i_wr_en, i_vcc_on, i_vpp_on;
   logic        i_io_card, i_win_wp_en, i_win_wr_req, o_rd_hit;
   logic        o_win_wr_allow, o_batt_dead, o_batt_low, o_batt_good;
   logic        rdy, wp, cd1_n, cd2_n, bvd1, bvd2;
   logic [11:0] i_addr;
   logic [7:0]  i_wr_data, o_rd_data, exp_b, exp_batt;
   logic [5:0]  pin_set;
   logic [7:0]  exp_q[$];
   logic [31:0] lfsr = 32'h17b2c;
   int          err_count = 0;
   int          comparisons = 0;
   pcis_card_model i_card (.i_state(pin_set), .o_card_ready(rdy),
      .o_card_wp(wp), .o_cd1_n(cd1_n), .o_cd2_n(cd2_n),
      .o_bvd1_stschg(bvd1), .o_bvd2_spkr(bvd2));
   pcis_status i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_addr(i_addr), .i_rd_en(i_rd_en), .i_wr_en(i_wr_en),
      .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit),
      .i_vcc_on(i_vcc_on), .i_vpp_on(i_vpp_on), .i_io_card(i_io_card),
      .i_win_wp_en(i_win_wp_en), .i_win_wr_req(i_win_wr_req),
      .o_win_wr_allow(o_win_wr_allow), .i_card_ready(rdy),
      .i_card_wp(wp), .i_cd1_n(cd1_n), .i_cd2_n(cd2_n),
      .i_bvd1_stschg(bvd1), .i_bvd2_spkr(bvd2), .o_batt_dead(o_batt_dead),
      .o_batt_low(o_batt_low), .o_batt_good(o_batt_good));
   // 200 MHz reference clock
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [31:0] next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // caller releases the strobe, so reads may follow back to back
   task automatic rd(input logic [11:0] a);
      i_addr = a;
      i_rd_en = 1'b1;
      @(posedge i_ref_clk);
      #1;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // answers compared against the oldest queued byte
   always @(negedge i_ref_clk) begin
      if (o_rd_hit === 1'b1) begin
         exp_b = (exp_q.size() == 0) ? 8'hxx : exp_q.pop_front();
         check(o_rd_data, exp_b);
      end
   end
   // random pins, power and window state; write ones, then read back
   initial begin
      {i_rd_en, i_wr_en, i_vcc_on, i_vpp_on, i_io_card} = 5'h00;
      {i_win_wp_en, i_win_wr_req, i_addr, i_wr_data, pin_set} = 28'h0;
      i_rstn = 1'b0;
      repeat (8) @(posedge i_ref_clk);
      #1 i_rstn = 1'b1;
      for (int n = 0; n < 40; n++) begin
         lfsr = next(lfsr);
         pin_set = lfsr[5:0];
         {i_vcc_on, i_vpp_on, i_io_card} = lfsr[8:6];
         {i_win_wp_en, i_win_wr_req} = lfsr[10:9];
         // write ones at the status offset with no read pending
         i_addr = 12'h801;
         i_wr_en = 1'b1;
         i_wr_data = 8'hff;
         // three edges: two synchroniser stages plus margin
         repeat (3) @(posedge i_ref_clk);
         #1;
         check({7'h0, o_win_wr_allow}, {7'h0, lfsr[9] & ~lfsr[10]});
         exp_batt = i_io_card ? 8'h00 : !pin_set[5] ? 8'h04 :
                    pin_set[4] ? 8'h01 : 8'h02;
         check({5'h0, o_batt_dead, o_batt_low, o_batt_good}, exp_batt);
         exp_q.push_back({1'b0, i_vcc_on & i_vpp_on, pin_set[0], pin_set[1],
            ~pin_set[3], ~pin_set[2], pin_set[5], pin_set[4]});
         rd(12'h801);
         rd(12'h001);
         i_rd_en = 1'b0;
         check({o_rd_hit, o_rd_data[6:0]}, 8'h00);
         $display("test %0d done", n);
      end
      end_of_test();
   end
   // hang guard, well beyond 40 loops of five cycles
   initial begin
      #5000;
      err_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
